// [dv/ees_bus_master.sv]
// behavioural two-wire bus master
`timescale 1ns/1ps
module ees_bus_master (
  // clock out, data drive (1 = release), resolved wire in
  output logic scl,
  output logic sda_o,
  input wire logic sda_w
);
  // idle bus, clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  // start from idle or repeated, clock left low
  task automatic start();
    #200 sda_o = 1'b1;
    #300 scl = 1'b1;
    #300 sda_o = 1'b0;
    #300 scl = 1'b0;
  endtask
  // stop, tail long enough for the write cycle to show
  task automatic stop();
    #200 sda_o = 1'b0;
    #300 scl = 1'b1;
    #300 sda_o = 1'b1;
    #600;
  endtask
  // nine clocks msb first, data moves only with the clock low
  task automatic io9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #200 sda_o = tx[i];
      #300 scl = 1'b1;
      #150 rx[i] = sda_w;
      #150 scl = 1'b0;
    end
  endtask
endmodule

// [dv/ees_slave_properties.sv]
// assertions on the memory slave pins
`timescale 1ns/1ps
module ees_slave_properties #(parameter int WR_CYC = 20) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // bus, straps, status
  input wire logic scl_in,
  input wire logic sda_in,
  input ees_pkg::ees_sda_s sda_pin,
  input ees_pkg::ees_sel_s sel_pins,
  input wire logic write_busy
);
  import ees_pkg::*;
  int bcnt;
  logic [3:0] rises;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // busy length, stalls with the design when frozen
  always_ff @(posedge mclk)
    if (!reset_n) bcnt <= 0;
    else if (clk_en) bcnt <= write_busy ? bcnt + 1 : 0;
  // clock rises since start, saturating so long pages stay safe
  always_ff @(posedge mclk)
    if (!reset_n || (scl_in && $fell(sda_in))) rises <= 4'h0;
    else if ($rose(scl_in) && rises != 4'hf) rises <= rises + 4'h1;
  AST_OUT_LOW: assert property (sda_pin.out == 1'b0)
    else $error("data output value not low");
  AST_BUSY_QUIET: assert property (write_busy |-> sda_pin.oe_n)
    else $error("data driven during write cycle");
  AST_FALL_EDGE: assert property ($changed(sda_pin.oe_n) |-> !scl_in)
    else $error("data output moved while clock high");
  AST_BUSY_STOP: assert property ($rose(write_busy) |->
    scl_in && sda_in && !$past(sda_in, 5))
    else $error("write cycle began without stop");
  AST_BUSY_LEN: assert property ($fell(write_busy) |-> bcnt == WR_CYC)
    else $error("write cycle length wrong");
  AST_ACK_STANDS: assert property ($fell(sda_pin.oe_n) |=>
    !sda_pin.oe_n [*5])
    else $error("driven low bit dropped early");
  AST_START_QUIET: assert property (scl_in && $fell(sda_in) |->
    sda_pin.oe_n [*8])
    else $error("data driven right after start");
  AST_FIRST_ACK: assert property ($fell(sda_pin.oe_n) && rises < 4'h9
    |-> rises == 4'h8)
    else $error("address acknowledge in wrong clock");
  cover property ($rose(write_busy));
  cover property ($fell(sda_pin.oe_n) && rises == 4'h8);
  cover property ($fell(write_busy));
endmodule
bind ees_slave ees_slave_properties #(.WR_CYC(WR_CYC)) u_props (
  .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl_in),
  .sda_in(sda_in), .sda_pin(sda_pin), .sel_pins(sel_pins),
  .write_busy(write_busy));

// [dv/ees_slave_tb_top.sv]
// self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
module ees_slave_tb_top;
  import ees_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic scl, sda_o, sda_w, write_busy;
  ees_sda_s sda_pin;
  ees_sel_s sel_pins = 3'h2;
  logic [8:0] rx;
  logic [7:0] wb [18];
  logic [7:0] eb [16];
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  // wired-and data line with pull-up
  assign sda_w = sda_o & (sda_pin.oe_n | sda_pin.out);
  ees_slave #(.HIGH_BITS(1), .WR_CYC(200)) uut (.mclk(mclk),
    .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_w),
    .sda_pin(sda_pin), .sel_pins(sel_pins), .write_busy(write_busy));
  ees_bus_master bus (.scl(scl), .sda_o(sda_o), .sda_w(sda_w));
  always #50 mclk = ~mclk;
  // hang guard far above the run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one byte out, acknowledge bit compared (0 = ack)
  task automatic snd(input logic [7:0] b, input logic a);
    bus.io9({b, 1'b1}, rx);
    chk({7'h0, rx[0]}, {7'h0, a});
  endtask
  task automatic w_idle();
    for (int k = 0; k < 400 && write_busy !== 1'b0; k++) @(posedge mclk);
    #10;
  endtask
  // write n bytes of wb from byte address ba
  task automatic wr(input logic [7:0] dev, input logic [7:0] ba, int n);
    bus.start();
    snd(dev, 1'b0);
    snd(ba, 1'b0);
    for (int i = 0; i < n; i++) snd(wb[i], 1'b0);
    bus.stop();
    chk({7'h0, write_busy}, 8'h1);
  endtask
  // selective read of n bytes from ba, compared with eb
  task automatic rd(input logic [7:0] dev, input logic [7:0] ba, int n);
    bus.start();
    snd(dev, 1'b0);
    snd(ba, 1'b0);
    bus.start();
    snd(dev | 8'h1, 1'b0);
    for (int i = 0; i < n; i++) begin
      bus.io9({8'hff, i == n - 1}, rx);
      chk(rx[8:1], eb[i]);
    end
    bus.stop();
  endtask
  // clocks with no start, wrong prefix, wrong strap: all ignored
  task automatic t_refuse();
    snd(8'ha4, 1'b1);
    bus.stop();
    bus.start();
    snd(8'hb4, 1'b1);
    bus.stop();
    bus.start();
    snd(8'hac, 1'b1);
    bus.stop();
  endtask
  // byte write, polls refused while busy, then both halves read back
  task automatic t_byte_poll();
    wb[0] = 8'h3c;
    wr(8'ha6, 8'h05, 1);
    // a freeze longer than the write cycle must hold the timer still
    clk_en = 1'b0;
    repeat (300) @(posedge mclk);
    #10 clk_en = 1'b1;
    chk({7'h0, write_busy}, 8'h1);
    bus.start();
    snd(8'ha6, 1'b1);
    bus.stop();
    w_idle();
    bus.start();
    snd(8'ha6, 1'b0);
    bus.stop();
    eb[0] = 8'h3c;
    eb[1] = ERASED;
    rd(8'ha6, 8'h05, 2);
    eb[0] = ERASED;
    rd(8'ha4, 8'h05, 1);
  endtask
  // eighteen bytes from 0x1e wrap in page over the first two
  task automatic t_page();
    for (int i = 0; i < 18; i++) begin
      wb[i] = 8'h40 + 8'(i);
      eb[(14 + i) % 16] = 8'h40 + 8'(i);
    end
    wr(8'ha4, 8'h1e, 18);
    w_idle();
    rd(8'ha4, 8'h10, 16);
  endtask
  // reset, quiet pins, then the scenarios
  initial begin
    repeat (8) @(posedge mclk);
    #10 reset_n = 1'b1;
    repeat (5) @(posedge mclk);
    #10;
    chk({6'h0, sda_pin.oe_n, write_busy}, 8'h2);
    t_refuse();
    t_byte_poll();
    t_page();
    close_out();
  end
endmodule

// [hw/ees_pkg.sv]
// constants, states and pin bundles for the two-wire memory slave
package ees_pkg;
  // fixed upper nibble of the slave address
  localparam logic [3:0] DEV_PREFIX = 4'ha;
  // page write buffer size and in-page index width
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_W = 4;
  // bits per byte and the counter value that marks the 9th clock
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACKED = 4'h9;
  // erased value of every byte after reset
  localparam logic [7:0] ERASED = 8'hff;
  // core clock rate and internal write time
  localparam int CLK_KHZ = 10000;
  localparam int WR_TIME_US = 5000;
  localparam int WR_CYCLES = (WR_TIME_US * CLK_KHZ + 999) / 1000;

  // bit engine states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_WORD = 7'h04,
    ST_WDATA = 7'h08,
    ST_ACK = 7'h10,
    ST_RDATA = 7'h20,
    ST_RACK = 7'h40
  } ees_state_e;

  // open-drain data pin, enable low while driving
  typedef struct packed {
    logic out;
    logic oe_n;
  } ees_sda_s;

  // external device select straps
  typedef struct packed {
    logic select_pin_2;
    logic select_pin_1;
    logic select_pin_0;
  } ees_sel_s;
endpackage

// [hw/ees_slave.sv]
// two-wire serial slave with embedded byte-wide memory and page buffer
`timescale 1ns/1ps

module ees_slave
  #(
    parameter int HIGH_BITS = 0,
    parameter int WR_CYC = ees_pkg::WR_CYCLES
  )
  (
    // clock, reset and freeze
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    // two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output ees_pkg::ees_sda_s sda_pin,
    // device select straps
    input ees_pkg::ees_sel_s sel_pins,
    // write cycle in progress
    output logic write_busy
  );
  import ees_pkg::*;

  // the array index grows with the density: eight byte address bits
  // plus up to three high bits lifted out of the slave address
  localparam int ADDR_W = 8 + HIGH_BITS;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int CW = $clog2(WR_CYC + 1);
  localparam logic [2:0] HI_MASK = 3'((1 << HIGH_BITS) - 1);
  localparam logic [10:0] AMASK = 11'(DEPTH - 1);

  // synchronised pins and their previous samples
  logic scl_meta, scl_sync, scl_last;
  logic sda_meta, sda_sync, sda_last;
  logic [2:0] sel_meta, sel_sync;
  // bus conditions and engine state
  logic scl_rise, scl_fall, start_seen, stop_seen;
  ees_state_e state, ack_next;
  logic [3:0] cnt;
  logic [7:0] shreg, txreg;
  logic [10:0] ptr;
  logic [2:0] hi_addr;
  // page buffer, array and write cycle timer
  logic [7:0] pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pvalid;
  logic wr_pend;
  logic [7:0] mem [DEPTH];
  logic [CW-1:0] busy_cnt;
  logic busy;
  // decoded strobes
  logic [2:0] sel_ok;
  logic rx_state, byte_end, addr_hit;
  logic take_addr_w, take_addr_r, take_word, take_data;
  logic load_tx, commit;
  logic [2:0] hi_rx;
  logic [7:0] rd_byte;

  // pins cross into mclk through two flops before use
  // the clock and data flops reset high so an idle bus at release shows no false edge;
  // a third copy of each line gives the edge detectors their history
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_last <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_last <= 1'b1;
      sel_meta <= 3'h0;
      sel_sync <= 3'h0;
    end else if (clk_en) begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_last <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_last <= sda_sync;
      sel_meta <= sel_pins;
      sel_sync <= sel_meta;
    end
  end

  // edges and bus conditions, both taken from the synced copies only
  // a start or stop needs the clock seen high on two samples in a row,
  // so a data change close to a clock edge is not mistaken for one
  assign scl_rise = scl_sync & ~scl_last;
  assign scl_fall = ~scl_sync & scl_last;
  assign start_seen = scl_sync & scl_last & sda_last & ~sda_sync;
  assign stop_seen = scl_sync & scl_last & ~sda_last & sda_sync;

  // select bits above the internal high bits must match the straps
  // with more high bits fewer straps take part, so the largest density
  // sits alone on the bus
  for (genvar g = 0; g < 3; g++) begin : g_sel
    assign sel_ok[g] = (g < HIGH_BITS) | (shreg[g+1] == sel_sync[g]);
  end

  // byte-level decode of the receive path
  // byte_end and the take strobes last one mclk and fire on the detected fall
  // that ends the eighth bit, so the ack goes out while clock is low
  assign rx_state = (state == ST_ADDR) | (state == ST_WORD)
                  | (state == ST_WDATA);
  assign byte_end = scl_fall & (cnt == BIT_LAST) & rx_state;
  assign hi_rx = shreg[3:1] & HI_MASK;
  // busy blocks every match, so polls see no acknowledge
  assign addr_hit = (shreg[7:4] == DEV_PREFIX) & (&sel_ok)
                  & ~busy;
  assign take_addr_w = byte_end & (state == ST_ADDR) & addr_hit
                     & ~shreg[0];
  assign take_addr_r = byte_end & (state == ST_ADDR) & addr_hit
                     & shreg[0];
  assign take_word = byte_end & (state == ST_WORD);
  assign take_data = byte_end & (state == ST_WDATA);
  assign load_tx = scl_fall & (((state == ST_ACK) & (ack_next == ST_RDATA))
                 | ((state == ST_RACK) & (cnt == BIT_ACKED)));
  assign commit = stop_seen & wr_pend & ~busy;
  assign rd_byte = mem[ptr[ADDR_W-1:0]];

  // bit engine: state, bit count and receive shifter
  // start and stop win over everything else, so a master may abort any
  // transfer; an unmatched address parks the engine until the next start
  // the shifter takes bits on detected rises only, which keeps a
  // glitch on the data line while the clock is low out of the byte
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      ack_next <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
    end else if (clk_en) begin
      if (start_seen) begin
        state <= ST_ADDR;
        cnt <= 4'h0;
      end else if (stop_seen) begin
        state <= ST_IDLE;
        cnt <= 4'h0;
      end else begin
        case (state)
          ST_IDLE: begin
            // nothing to do until a start arrives
            cnt <= 4'h0;
          end
          ST_ADDR, ST_WORD, ST_WDATA: begin
            if (scl_rise && cnt < BIT_LAST) begin
              shreg <= {shreg[6:0], sda_sync};
              cnt <= cnt + 4'h1;
            end else if (byte_end) begin
              if (state != ST_ADDR) begin
                state <= ST_ACK;
                ack_next <= ST_WDATA;
              end else if (addr_hit) begin
                state <= ST_ACK;
                ack_next <= shreg[0] ? ST_RDATA : ST_WORD;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              state <= ack_next;
              cnt <= 4'h0;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == BIT_LAST) begin
              state <= ST_RACK;
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda_sync) begin
                state <= ST_IDLE;
              end else begin
                cnt <= BIT_ACKED;
              end
            end else if (scl_fall && cnt == BIT_ACKED) begin
              state <= ST_RDATA;
              cnt <= 4'h0;
            end
          end
          default: begin
            state <= ST_IDLE;
            cnt <= 4'h0;
          end
        endcase
      end
    end
  end

  // data pin driver, every change lands on a falling clock
  // the pin only ever pulls low; a one is sent by letting go, so two
  // slaves answering at once cannot fight on the wire
  // changes follow the detected fall by one mclk, well inside the low
  // half of the bus clock at any rate the synchronisers can follow
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sda_pin.out <= 1'b0;
      sda_pin.oe_n <= 1'b1;
      txreg <= 8'h00;
    end else if (clk_en) begin
      sda_pin.out <= 1'b0;
      if (start_seen || stop_seen || busy) begin
        sda_pin.oe_n <= 1'b1;
      end else if (byte_end) begin
        // ack only what the engine accepts
        sda_pin.oe_n <= ~((state != ST_ADDR) | addr_hit);
      end else if (load_tx) begin
        sda_pin.oe_n <= rd_byte[7];
        txreg <= {rd_byte[6:0], 1'b0};
      end else if (scl_fall && state == ST_RDATA) begin
        if (cnt == BIT_LAST) begin
          sda_pin.oe_n <= 1'b1;
        end else begin
          sda_pin.oe_n <= txreg[7];
          txreg <= {txreg[6:0], 1'b0};
        end
      end else if (scl_fall && state == ST_ACK) begin
        sda_pin.oe_n <= 1'b1;
      end
    end
  end

  // address pointer and high bits taken from the slave address
  // writes step only the low nibble, reads step the whole pointer;
  // a refused address leaves the pointer where it was
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ptr <= 11'h000;
      hi_addr <= 3'h0;
    end else if (clk_en) begin
      if (take_addr_w) begin
        hi_addr <= hi_rx;
      end else if (take_addr_r) begin
        hi_addr <= hi_rx;
        ptr <= {hi_rx, ptr[7:0]};
      end else if (take_word) begin
        ptr <= {hi_addr, shreg};
      end else if (take_data) begin
        // wraps inside the page, page bits untouched
        ptr <= {ptr[10:4], ptr[3:0] + 4'h1};
      end else if (scl_rise && state == ST_RACK) begin
        // reads wrap at the end of the whole array
        ptr <= (ptr + 11'h001) & AMASK;
      end
    end
  end

  // page buffer collects bytes until stop
  // only bytes that arrived are marked valid, so a short page leaves
  // the rest of that page in the array untouched at commit
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pvalid <= '0;
      wr_pend <= 1'b0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        pbuf[i] <= 8'h00;
      end
    end else if (clk_en) begin
      if (take_addr_w) begin
        pvalid <= '0;
        wr_pend <= 1'b0;
      end else if (take_data) begin
        pbuf[ptr[3:0]] <= shreg;
        pvalid[ptr[3:0]] <= 1'b1;
        wr_pend <= 1'b1;
      end else if (commit || start_seen) begin
        // a restart without stop drops an unfinished write
        wr_pend <= 1'b0;
      end
    end
  end

  // array: every valid buffered byte of the page lands in one cycle at stop
  // flops keep the model plain; a real part would use a macro with a
  // page-wide write port
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= ERASED;
      end
    end else if (clk_en && commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pvalid[i]) begin
          mem[{ptr[ADDR_W-1:PAGE_W], 4'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // write cycle timer holds the slave deaf until it runs out
  // polls during the count change nothing; a freeze through clk_en
  // stretches the cycle by the frozen time
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      busy <= 1'b0;
      busy_cnt <= '0;
      write_busy <= 1'b0;
    end else if (clk_en) begin
      if (commit) begin
        busy <= 1'b1;
        busy_cnt <= CW'(WR_CYC - 1);
        write_busy <= 1'b1;
      end else if (busy) begin
        if (busy_cnt == '0) begin
          busy <= 1'b0;
          write_busy <= 1'b0;
        end else begin
          busy_cnt <= busy_cnt - CW'(1);
        end
      end
    end
  end

endmodule
